// ===== design/low_power_state_pkg.sv
// Constants and state type of the low-power state controller.
// Assumes a single 200 MHz clock domain and a synchronous reset.
`default_nettype none
package low_power_state_pkg;
    // ***************************************************
    // States
    // ***************************************************
    typedef enum logic [2:0] {
        RUNNING,
        HALT_ENTRY,
        CORE_HALT,
        SLEEP,
        DEEP_SLEEP
    } power_state_t;

    // ***************************************************
    // Synchroniser and acknowledge
    // ***************************************************
    localparam int SYNC_STAGES = 3;
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam int ACK_CYCLES = 1;
    localparam logic [7:0] ACK_CODE = 8'h01;
    localparam logic [7:0] ACK_IDLE = 8'h00;
endpackage
`default_nettype wire

// ===== design/request_sync.sv
// Three-stage synchroniser with agreement filter for one active-low pin.
// Assumes the pin is asynchronous to ref_clk; idle level is high.
`default_nettype none
module request_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Pin and clean level
    input wire logic pin_n,
    output logic level_n
);
    logic [2:0] stage;
    wire agree = (stage[1] == stage[2]);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage <= low_power_state_pkg::SYNC_RESET;
        end else begin
            stage <= {stage[1:0], pin_n};
        end
    end

    // Level moves only when stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_n <= 1'b1;
        end else if (agree) begin
            level_n <= stage[2];
        end
    end
endmodule
`default_nettype wire

// ===== design/low_power_state_control.sv
// Low-power state controller: running, core halt, sleep and deep sleep.
// Assumes the platform controller drives the three request pins
// asynchronously; the bus clock is outside and is never gated here.
`default_nettype none
module low_power_state_control (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Request pins from platform controller
    input wire logic clock_halt_request_n,
    input wire logic sleep_request_n,
    input wire logic deep_sleep_request_n,
    // Clock gates
    output logic core_clock_en,
    output logic bus_unit_clock_en,
    output logic interrupt_controller_unit_clock_en,
    output logic pll_run,
    // Service enables
    output logic snoop_en,
    output logic interrupt_en,
    output logic execute_en,
    // Acknowledge transaction on the system bus
    output logic ack_valid,
    output logic [7:0] ack_code,
    // State for observation
    output logic [2:0] power_state
);
    // ***************************************************
    // Synchronisers
    // ***************************************************
    logic halt_n;
    logic sleep_n;
    logic deep_n;

    request_sync halt_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_n(clock_halt_request_n),
        .level_n(halt_n)
    );
    request_sync sleep_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_n(sleep_request_n),
        .level_n(sleep_n)
    );
    request_sync deep_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_n(deep_sleep_request_n),
        .level_n(deep_n)
    );

    // ***************************************************
    // State machine
    // ***************************************************
    low_power_state_pkg::power_state_t state;
    low_power_state_pkg::power_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            low_power_state_pkg::RUNNING: begin
                if (!halt_n) next_state = low_power_state_pkg::HALT_ENTRY;
            end
            low_power_state_pkg::HALT_ENTRY: begin
                next_state = low_power_state_pkg::CORE_HALT;
            end
            low_power_state_pkg::CORE_HALT: begin
                if (!sleep_n) next_state = low_power_state_pkg::SLEEP;
                else if (halt_n) next_state = low_power_state_pkg::RUNNING;
            end
            low_power_state_pkg::SLEEP: begin
                // Halt pin is ignored here
                if (!deep_n) next_state = low_power_state_pkg::DEEP_SLEEP;
                else if (sleep_n) next_state = low_power_state_pkg::CORE_HALT;
            end
            low_power_state_pkg::DEEP_SLEEP: begin
                if (deep_n) next_state = low_power_state_pkg::SLEEP;
            end
            default: next_state = low_power_state_pkg::RUNNING;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= low_power_state_pkg::RUNNING;
        end else begin
            state <= next_state;
        end
    end

    // ***************************************************
    // Output decode of the next state
    // ***************************************************
    wire next_run = (next_state == low_power_state_pkg::RUNNING);
    wire next_halt = (next_state == low_power_state_pkg::HALT_ENTRY) ||
        (next_state == low_power_state_pkg::CORE_HALT);
    wire next_deep = (next_state == low_power_state_pkg::DEEP_SLEEP);
    wire next_ack = (next_state == low_power_state_pkg::HALT_ENTRY);
    wire next_awake = next_run || next_halt;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_clock_en <= 1'b1;
            bus_unit_clock_en <= 1'b1;
            interrupt_controller_unit_clock_en <= 1'b1;
            pll_run <= 1'b1;
            snoop_en <= 1'b1;
            interrupt_en <= 1'b1;
            execute_en <= 1'b1;
            ack_valid <= 1'b0;
            ack_code <= low_power_state_pkg::ACK_IDLE;
            power_state <= 3'h0;
        end else begin
            core_clock_en <= next_run;
            bus_unit_clock_en <= next_awake;
            interrupt_controller_unit_clock_en <= next_awake;
            pll_run <= !next_deep;
            snoop_en <= next_awake;
            interrupt_en <= next_awake;
            execute_en <= next_run;
            ack_valid <= next_ack;
            ack_code <= next_ack ? low_power_state_pkg::ACK_CODE
                                 : low_power_state_pkg::ACK_IDLE;
            power_state <= next_state;
        end
    end

    // ***************************************************
    // Assertions
    // ***************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence enter_halt_s;
        state == low_power_state_pkg::RUNNING && !halt_n;
    endsequence

    sequence ack_pulse_s;
        ack_valid && ack_code == low_power_state_pkg::ACK_CODE ##1 !ack_valid;
    endsequence

    sequence leave_sleep_s;
        state == low_power_state_pkg::SLEEP && sleep_n && deep_n;
    endsequence

    halt_ack_a: assert property (enter_halt_s |=> ack_pulse_s)
        else $error("Halt entry not acknowledged once");
    ack_code_a: assert property (ack_code == (ack_valid ? low_power_state_pkg::ACK_CODE
        : low_power_state_pkg::ACK_IDLE))
        else $error("Acknowledge code wrong");
    entry_once_a: assert property (state == low_power_state_pkg::HALT_ENTRY |=>
        state == low_power_state_pkg::CORE_HALT)
        else $error("Halt entry lasted too long");
    halt_gates_a: assert property (state == low_power_state_pkg::CORE_HALT |->
        !core_clock_en && bus_unit_clock_en && interrupt_controller_unit_clock_en)
        else $error("Core halt clock gating wrong");
    halt_service_a: assert property (state == low_power_state_pkg::CORE_HALT |->
        snoop_en && interrupt_en)
        else $error("Core halt stopped servicing");
    halt_exit_a: assert property (state == low_power_state_pkg::CORE_HALT && halt_n
        && sleep_n |=> core_clock_en && execute_en)
        else $error("Halt release did not resume");
    run_gates_a: assert property (state == low_power_state_pkg::RUNNING |->
        core_clock_en && bus_unit_clock_en && interrupt_controller_unit_clock_en
        && execute_en && snoop_en && interrupt_en && !ack_valid)
        else $error("Running state not fully clocked");
    run_hold_a: assert property (state == low_power_state_pkg::RUNNING && halt_n
        |=> state == low_power_state_pkg::RUNNING)
        else $error("Running left without halt request");
    sleep_entry_a: assert property (state == low_power_state_pkg::CORE_HALT && !sleep_n
        |=> state == low_power_state_pkg::SLEEP)
        else $error("Sleep not entered");
    sleep_gates_a: assert property (state == low_power_state_pkg::SLEEP |->
        !bus_unit_clock_en && !core_clock_en && !interrupt_controller_unit_clock_en
        && pll_run)
        else $error("Sleep clock gating wrong");
    sleep_ignore_a: assert property (state == low_power_state_pkg::SLEEP |->
        !snoop_en && !interrupt_en)
        else $error("Sleep serviced a request");
    sleep_halt_pin_a: assert property (state == low_power_state_pkg::SLEEP && !sleep_n
        && deep_n |=> state == low_power_state_pkg::SLEEP)
        else $error("Sleep left on ignored input");
    sleep_exit_a: assert property (leave_sleep_s |=>
        state == low_power_state_pkg::CORE_HALT && bus_unit_clock_en
        && interrupt_controller_unit_clock_en)
        else $error("Sleep release wrong");
    deep_entry_a: assert property (state == low_power_state_pkg::SLEEP && !deep_n
        |=> state == low_power_state_pkg::DEEP_SLEEP)
        else $error("Deep sleep not entered");
    deep_gates_a: assert property (state == low_power_state_pkg::DEEP_SLEEP |->
        !core_clock_en && !bus_unit_clock_en && !interrupt_controller_unit_clock_en
        && !snoop_en && !interrupt_en && !execute_en && !pll_run)
        else $error("Deep sleep clock gating wrong");
    deep_exit_a: assert property (state == low_power_state_pkg::DEEP_SLEEP && deep_n
        |=> state == low_power_state_pkg::SLEEP)
        else $error("Deep sleep release wrong");
    deep_hold_a: assert property (state == low_power_state_pkg::DEEP_SLEEP
        && !deep_n |=> state == low_power_state_pkg::DEEP_SLEEP)
        else $error("Deep sleep left while requested");
    state_view_a: assert property (power_state == state)
        else $error("Observed state differs from state");
    sync_delay_a: assert property ($fell(halt_n) |->
        $past(clock_halt_request_n, 3) == 1'b0)
        else $error("Halt level faster than sync");
endmodule
`default_nettype wire

// ===== tb/platform_pm_model.sv
// Platform power controller model: drives the three request pins.
// Assumes the bench calls drive; the pins idle high until told otherwise.
`default_nettype none
module platform_pm_model (
    // Clock used only to place pin changes between edges
    input wire logic ref_clk,
    // Request pins
    output logic clock_halt_request_n,
    output logic sleep_request_n,
    output logic deep_sleep_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        clock_halt_request_n = 1'b1;
        sleep_request_n = 1'b1;
        deep_sleep_request_n = 1'b1;
    end
    // Levels move off the edge; the clock itself is never touched
    task automatic drive(input logic h, input logic s, input logic d);
        @(posedge ref_clk);
        #1;
        clock_halt_request_n = h;
        sleep_request_n = s;
        deep_sleep_request_n = d;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_low_power_state_control.sv
// Testbench of the low-power state controller.
// Assumes the platform model drives the pins; notes are checked on any output change.
`default_nettype none
module tb_low_power_state_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    wire logic halt_n, sleep_n, deep_n;
    logic core_en, bus_en, intc_en, pll, snoop, intr, exec_en, ack;
    logic [7:0] code;
    logic [2:0] state;
    logic [18:0] last = {3'h0, 8'hfe, low_power_state_pkg::ACK_IDLE};
    logic [18:0] notes[$];
    int failures = 0;
    int n_checks = 0;
    wire logic [18:0] obs = {state, core_en, bus_en, intc_en, pll, snoop, intr, exec_en, ack,
        code};
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    platform_pm_model pm (.ref_clk(ref_clk), .clock_halt_request_n(halt_n),
        .sleep_request_n(sleep_n), .deep_sleep_request_n(deep_n));
    low_power_state_control dut (.ref_clk(ref_clk), .reset(reset),
        .clock_halt_request_n(halt_n), .sleep_request_n(sleep_n),
        .deep_sleep_request_n(deep_n), .core_clock_en(core_en), .bus_unit_clock_en(bus_en),
        .interrupt_controller_unit_clock_en(intc_en), .pll_run(pll), .snoop_en(snoop),
        .interrupt_en(intr), .execute_en(exec_en), .ack_valid(ack), .ack_code(code),
        .power_state(state));
    function automatic logic [18:0] note(input logic [2:0] s);
        logic halted, asleep, deep, entry;
        halted = (s != 3'h0);
        asleep = (s == 3'h3) || (s == 3'h4);
        deep = (s == 3'h4);
        entry = (s == 3'h1);
        return {s, ~halted, ~asleep, ~asleep, ~deep, ~asleep, ~asleep, ~halted, entry,
            entry ? low_power_state_pkg::ACK_CODE : low_power_state_pkg::ACK_IDLE};
    endfunction
    task automatic check(input logic [18:0] seen, input logic [18:0] want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Any output change takes the oldest note; an unexpected one fails
    always @(posedge ref_clk) begin
        #2;
        if (obs !== last) begin
            check(obs, notes.size() > 0 ? notes.pop_front() : ~obs);
        end
        last = obs;
    end
    // Drives pins, notes up to two expected states, waits bounded
    task automatic step(input logic h, s, d, input logic [2:0] a, b, input int n);
        for (int i = 0; i < n; i++) notes.push_back(note(i ? b : a));
        pm.drive(h, s, d);
        for (int i = 0; i < 20 && notes.size() > 0; i++) @(posedge ref_clk);
        if (notes.size() > 0) begin
            failures++;
            end_sim();
        end else begin
            repeat (6 + $urandom % 8) @(posedge ref_clk);
        end
    endtask
    initial begin
        void'($urandom(32'hdbc1));
        repeat (16) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (2) begin
            step(1, 0, 1, 0, 0, 0);
            step(1, 1, 1, 0, 0, 0);
            step(0, 1, 1, 3'h1, 3'h2, 2);
            step(0, 1, 0, 0, 0, 0);
            step(0, 1, 1, 0, 0, 0);
            step(0, 0, 1, 3'h3, 0, 1);
            step(1'($urandom), 0, 1, 0, 0, 0);
            step(1, 0, 0, 3'h4, 0, 1);
            step(1, 0, 1, 3'h3, 0, 1);
            step(1, 1, 1, 3'h2, 3'h0, 2);
        end
        step(0, 1, 1, 3'h1, 3'h2, 2);
        step(1, 0, 1, 3'h3, 0, 1);
        step(1, 0, 0, 3'h4, 0, 1);
        notes.push_back(note(3'h0));
        pm.drive(1, 1, 1);
        reset = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 reset = 1'b0;
        step(1, 1, 1, 0, 0, 0);
        end_sim();
    end
endmodule
`default_nettype wire
